//--- core/pdm_defines.svh
/*
 Constants of the port direction and pin-function mux: register indexes,
 reset values, field positions and masks.
 Assumes inclusion from the package, the mux module and the bench only.
*/
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_SLOTS 26
`define PDM_IDX_WIDTH 8
`define PDM_DATA_WIDTH 8

// Register indexes; byte address is four times the index
`define PDM_IDX_PORT1_DIR 8'h06
`define PDM_IDX_PORT1_FN 8'h07
`define PDM_IDX_PORT4_DIR 8'h12
`define PDM_IDX_PORT4_FN 8'h13
`define PDM_IDX_PORT5_DIR 8'h16
`define PDM_IDX_PORT5_FN 8'h17
`define PDM_IDX_PORT6_DIR 8'h1A
`define PDM_IDX_PORT6_FN 8'h1B
`define PDM_IDX_PORT7_DATA 8'h1C
`define PDM_IDX_PORT7_DIR 8'h1E
`define PDM_IDX_PORT7_FN 8'h1F
`define PDM_IDX_PORT8_FN2 8'h21
`define PDM_IDX_PORT8_DIR 8'h22
`define PDM_IDX_PORT8_FN 8'h23
`define PDM_IDX_PORTC_FN 8'h33
`define PDM_IDX_PORTD_FN2 8'h35
`define PDM_IDX_PORTD_DIR 8'h36
`define PDM_IDX_PORTD_FN 8'h37
`define PDM_IDX_PORTF_FN2 8'h3D
`define PDM_IDX_PORTF_DIR 8'h3E
`define PDM_IDX_PORTF_FN 8'h3F
`define PDM_IDX_PORTG_FN 8'h43
`define PDM_IDX_PORTL_FN 8'h57
`define PDM_IDX_PORTN_DIR 8'h5E
`define PDM_IDX_PORTN_FN 8'h5F
`define PDM_IDX_SERIAL_SEL 8'hF4
`define PDM_IDX_STATUS 8'h80

// Reset values
`define PDM_RST_ZERO 8'h00
`define PDM_RST_PORT8_DIR 8'h08
`define PDM_RST_PORTG_FN 8'hFF
`define PDM_RST_PORTL_FN 8'h0F
`define PDM_RST_PORT7_DATA 8'h0F

// Field positions and masks
`define PDM_BIT_DATABUS_HIGH 0
`define PDM_PIN_WAIT 3
`define PDM_BIT_SERIAL_SEL 0
`define PDM_MASK_SERIAL_SEL 8'h01
`define PDM_OD_CODE 3'b111
`define PDM_STAT_PULLUP_LSB 0
`define PDM_STAT_WAIT 4
`define PDM_STAT_FAST 5
`define PDM_STAT_DATABUS 6

`endif

//--- core/pdm_pkg.sv
/*
 Types of the port direction and pin-function mux: register slots, bus
 request, pin inputs, mux outputs and the module state.
 Assumes pdm_defines.svh is on the include path.
*/
`include "pdm_defines.svh"

package pdm_pkg;

    typedef enum logic [4:0] {
        SLOT_PORT1_DIR, SLOT_PORT1_FN, SLOT_PORT4_DIR, SLOT_PORT4_FN,
        SLOT_PORT5_DIR, SLOT_PORT5_FN, SLOT_PORT6_DIR, SLOT_PORT6_FN,
        SLOT_PORT7_DIR, SLOT_PORT7_FN, SLOT_PORT8_FN2, SLOT_PORT8_DIR,
        SLOT_PORT8_FN, SLOT_PORTC_FN, SLOT_PORTD_FN2, SLOT_PORTD_DIR,
        SLOT_PORTD_FN, SLOT_PORTF_FN2, SLOT_PORTF_DIR, SLOT_PORTF_FN,
        SLOT_PORTG_FN, SLOT_PORTL_FN, SLOT_PORTN_DIR, SLOT_PORTN_FN,
        SLOT_PORT7_DATA, SLOT_SERIAL_SEL, SLOT_NONE
    } pdm_slot_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } pdm_ahb_req_t;

    typedef struct packed {
        logic [3:0] portC;
        logic [4:0] portD;
        logic [4:0] portDOutData;
    } pdm_pins_t;

    typedef struct packed {
        logic dataBusHigh;
        logic [23:0] addrBusEn;
        logic [39:0] portDir;
        logic [7:0] port7Dir;
        logic [4:0] port7Function;
        logic [3:0] port7PullUp;
        logic [2:0] chipSelectEn;
        logic chipSelect3En;
        logic waitInputEn;
        logic [2:0] timerOutSel;
        logic timerA0Clock;
        logic [1:0] timerB1Capture;
        logic serial2Rx;
        logic serial2Clk;
        logic serial2Cts;
        logic [4:0] portDOutEn;
        logic [5:0] portFOutEn;
        logic serial1En;
        logic fastSerialEn;
        logic [7:0] analogGEn;
        logic [3:0] analogLEn;
    } pdm_mux_t;

    typedef struct packed {
        logic [`PDM_SLOTS-1:0][`PDM_DATA_WIDTH-1:0] cfg;
        logic [31:0] rdData;
        logic readyOut;
        logic respErr;
        logic wrPend;
        pdm_slot_t wrSlot;
        pdm_mux_t mux;
    } pdm_state_t;

endpackage : pdm_pkg

//--- core/pdm_port_mux.sv
/*
 Port direction and pin-function selection for the general-purpose ports,
 with its write-only configuration registers behind an AHB-Lite slave.
 Assumes a single-master AHB-Lite bus on sys_clk, word transfers only, and
 pin inputs already synchronous to sys_clk.
*/
// Functional notes
// - With port-7 pins 0 to 3 as inputs, each data latch bit switches that pin's pull-up, 0 off and 1 on.
// - Port-C pin 0 always feeds the first 8-bit timer's clock input.
// - Both capture pins of the second 16-bit timer always feed that timer.
// - Serial channel 2 receive and clock pins always feed that channel, the clock pin (port-D pin 4) also as clear-to-send.
// - Port-D pin 2 has no open-drain choice and drives push-pull as an output.
// - Port-F pins 0 and 3 have no open-drain choice and drive push-pull as outputs.
// - For ports G and L as analog inputs the converter picks channel and trigger, not the function bits.
// - A one-bit serial selector with the port-F function bits chooses serial channel 1 or the fast channel.
// - Port-1 function bit 0 turns the port-1 pins into upper data bus bits 8 to 15.
`timescale 1ns/1ps
`include "pdm_defines.svh"

module pdm_port_mux (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pdm_pkg::pdm_ahb_req_t ahbReq,
    input wire logic hready,
    input wire pdm_pkg::pdm_pins_t pinsIn,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output pdm_pkg::pdm_mux_t muxOut
);

    localparam logic [`PDM_SLOTS*`PDM_DATA_WIDTH-1:0] CFG_RESET = {
        `PDM_RST_ZERO,
        `PDM_RST_PORT7_DATA,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_PORTL_FN,
        `PDM_RST_PORTG_FN,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_PORT8_DIR,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO,
        `PDM_RST_ZERO
    };

    // Maps a register index to its storage slot
    function automatic pdm_pkg::pdm_slot_t slotOf(input logic [`PDM_IDX_WIDTH-1:0] idx);
        pdm_pkg::pdm_slot_t s;
        s = pdm_pkg::SLOT_NONE;
        case (idx)
            `PDM_IDX_PORT1_DIR: s = pdm_pkg::SLOT_PORT1_DIR;
            `PDM_IDX_PORT1_FN: s = pdm_pkg::SLOT_PORT1_FN;
            `PDM_IDX_PORT4_DIR: s = pdm_pkg::SLOT_PORT4_DIR;
            `PDM_IDX_PORT4_FN: s = pdm_pkg::SLOT_PORT4_FN;
            `PDM_IDX_PORT5_DIR: s = pdm_pkg::SLOT_PORT5_DIR;
            `PDM_IDX_PORT5_FN: s = pdm_pkg::SLOT_PORT5_FN;
            `PDM_IDX_PORT6_DIR: s = pdm_pkg::SLOT_PORT6_DIR;
            `PDM_IDX_PORT6_FN: s = pdm_pkg::SLOT_PORT6_FN;
            `PDM_IDX_PORT7_DATA: s = pdm_pkg::SLOT_PORT7_DATA;
            `PDM_IDX_PORT7_DIR: s = pdm_pkg::SLOT_PORT7_DIR;
            `PDM_IDX_PORT7_FN: s = pdm_pkg::SLOT_PORT7_FN;
            `PDM_IDX_PORT8_FN2: s = pdm_pkg::SLOT_PORT8_FN2;
            `PDM_IDX_PORT8_DIR: s = pdm_pkg::SLOT_PORT8_DIR;
            `PDM_IDX_PORT8_FN: s = pdm_pkg::SLOT_PORT8_FN;
            `PDM_IDX_PORTC_FN: s = pdm_pkg::SLOT_PORTC_FN;
            `PDM_IDX_PORTD_FN2: s = pdm_pkg::SLOT_PORTD_FN2;
            `PDM_IDX_PORTD_DIR: s = pdm_pkg::SLOT_PORTD_DIR;
            `PDM_IDX_PORTD_FN: s = pdm_pkg::SLOT_PORTD_FN;
            `PDM_IDX_PORTF_FN2: s = pdm_pkg::SLOT_PORTF_FN2;
            `PDM_IDX_PORTF_DIR: s = pdm_pkg::SLOT_PORTF_DIR;
            `PDM_IDX_PORTF_FN: s = pdm_pkg::SLOT_PORTF_FN;
            `PDM_IDX_PORTG_FN: s = pdm_pkg::SLOT_PORTG_FN;
            `PDM_IDX_PORTL_FN: s = pdm_pkg::SLOT_PORTL_FN;
            `PDM_IDX_PORTN_DIR: s = pdm_pkg::SLOT_PORTN_DIR;
            `PDM_IDX_PORTN_FN: s = pdm_pkg::SLOT_PORTN_FN;
            `PDM_IDX_SERIAL_SEL: s = pdm_pkg::SLOT_SERIAL_SEL;
            default: s = pdm_pkg::SLOT_NONE;
        endcase
        return s;
    endfunction : slotOf

    // Port F pins 3 to 5 go to a serial channel when any of their function bits is set
    function automatic logic portFSerial(input logic [`PDM_DATA_WIDTH-1:0] fn);
        return |fn[5:3];
    endfunction : portFSerial

    pdm_pkg::pdm_state_t st;
    pdm_pkg::pdm_state_t next_st;

    logic addrPhase;
    logic [`PDM_IDX_WIDTH-1:0] reqIdx;

    assign addrPhase = ahbReq.hsel && ahbReq.htrans[1] && hready;
    assign reqIdx = ahbReq.haddr[`PDM_IDX_WIDTH+1:2];

    always_comb begin
        logic [`PDM_SLOTS-1:0][`PDM_DATA_WIDTH-1:0] c;
        logic [2:0] pd1Code;
        logic [7:0] wrByte;
        c = st.cfg;
        pd1Code = 3'h0;
        wrByte = 8'h00;
        next_st = st;
        next_st.readyOut = 1'b1;
        next_st.respErr = 1'b0;

        // Data phase: commit the current hwdata byte to the slot captured in the previous address phase
        if (st.wrPend && st.wrSlot != pdm_pkg::SLOT_NONE) begin
            wrByte = ahbReq.hwdata[`PDM_DATA_WIDTH-1:0];
            if (st.wrSlot == pdm_pkg::SLOT_SERIAL_SEL) begin
                wrByte = wrByte & `PDM_MASK_SERIAL_SEL;
            end
            next_st.cfg[st.wrSlot] = wrByte;
        end

        // Address phase; configuration is write-only so only status reads back
        next_st.wrPend = addrPhase && ahbReq.hwrite;
        next_st.wrSlot = slotOf(reqIdx);
        if (addrPhase && !ahbReq.hwrite) begin
            next_st.rdData = 32'h0000_0000;
            if (reqIdx == `PDM_IDX_STATUS) begin
                next_st.rdData[`PDM_STAT_PULLUP_LSB +: 4] = st.mux.port7PullUp;
                next_st.rdData[`PDM_STAT_WAIT] = st.mux.waitInputEn;
                next_st.rdData[`PDM_STAT_FAST] = st.mux.fastSerialEn;
                next_st.rdData[`PDM_STAT_DATABUS] = st.mux.dataBusHigh;
            end
        end

        // Pin function decode from the stored configuration
        next_st.mux.dataBusHigh = c[pdm_pkg::SLOT_PORT1_FN][`PDM_BIT_DATABUS_HIGH];
        next_st.mux.addrBusEn = {
            c[pdm_pkg::SLOT_PORT6_FN],
            c[pdm_pkg::SLOT_PORT5_FN],
            c[pdm_pkg::SLOT_PORT4_FN]
        };
        next_st.mux.portDir = {
            c[pdm_pkg::SLOT_PORTN_DIR],
            c[pdm_pkg::SLOT_PORT6_DIR],
            c[pdm_pkg::SLOT_PORT5_DIR],
            c[pdm_pkg::SLOT_PORT4_DIR],
            c[pdm_pkg::SLOT_PORT1_DIR]
        };
        next_st.mux.port7Dir = c[pdm_pkg::SLOT_PORT7_DIR];
        next_st.mux.port7Function = c[pdm_pkg::SLOT_PORT7_FN][4:0];
        // Pull-up only on an input pin whose latch holds 1
        next_st.mux.port7PullUp = ~c[pdm_pkg::SLOT_PORT7_DIR][3:0]
                                  & c[pdm_pkg::SLOT_PORT7_DATA][3:0];
        next_st.mux.chipSelectEn = c[pdm_pkg::SLOT_PORT8_FN][2:0];
        next_st.mux.chipSelect3En = c[pdm_pkg::SLOT_PORT8_DIR][`PDM_PIN_WAIT]
                                    & c[pdm_pkg::SLOT_PORT8_FN][`PDM_PIN_WAIT];
        next_st.mux.waitInputEn = ~c[pdm_pkg::SLOT_PORT8_DIR][`PDM_PIN_WAIT]
                                  & c[pdm_pkg::SLOT_PORT8_FN][`PDM_PIN_WAIT];
        next_st.mux.timerOutSel = {
            c[pdm_pkg::SLOT_PORT8_FN2][3],
            c[pdm_pkg::SLOT_PORT8_FN2][1:0]
        };
        // Timer and serial-2 inputs bypass the function settings entirely
        next_st.mux.timerA0Clock = pinsIn.portC[0];
        next_st.mux.timerB1Capture = pinsIn.portD[2:1];
        next_st.mux.serial2Rx = pinsIn.portD[3];
        next_st.mux.serial2Clk = pinsIn.portD[4];
        next_st.mux.serial2Cts = pinsIn.portD[4];
        // Only pin 1 can go open-drain; pin 2 always push-pull
        pd1Code = {
            c[pdm_pkg::SLOT_PORTD_FN2][1],
            c[pdm_pkg::SLOT_PORTD_FN][1],
            c[pdm_pkg::SLOT_PORTD_DIR][1]
        };
        next_st.mux.portDOutEn = c[pdm_pkg::SLOT_PORTD_DIR][4:0];
        if (pd1Code == `PDM_OD_CODE) begin
            next_st.mux.portDOutEn[1] = ~pinsIn.portDOutData[1];
        end
        next_st.mux.portFOutEn = c[pdm_pkg::SLOT_PORTF_DIR][5:0];
        next_st.mux.serial1En = ~c[pdm_pkg::SLOT_SERIAL_SEL][`PDM_BIT_SERIAL_SEL]
                                & portFSerial(c[pdm_pkg::SLOT_PORTF_FN]);
        next_st.mux.fastSerialEn = c[pdm_pkg::SLOT_SERIAL_SEL][`PDM_BIT_SERIAL_SEL]
                                   & portFSerial(c[pdm_pkg::SLOT_PORTF_FN]);
        // Channel and trigger choice stays with the converter itself
        next_st.mux.analogGEn = c[pdm_pkg::SLOT_PORTG_FN];
        next_st.mux.analogLEn = c[pdm_pkg::SLOT_PORTL_FN][3:0];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.cfg <= CFG_RESET;
            st.readyOut <= 1'b1;
            st.wrSlot <= pdm_pkg::SLOT_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = st.readyOut;
    assign hresp = st.respErr;
    assign hrdata = st.rdData;
    assign muxOut = st.mux;

    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_bus_ready_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not OKAY");

    a_pullup_from_latch: assert property ($past(rst_n) |->
        muxOut.port7PullUp == ($past(~st.cfg[pdm_pkg::SLOT_PORT7_DIR][3:0])
                               & $past(st.cfg[pdm_pkg::SLOT_PORT7_DATA][3:0])))
        else $error("pull-up does not follow latch and direction");

    a_timer_clock_pass: assert property ($past(rst_n) |-> muxOut.timerA0Clock == $past(pinsIn.portC[0]))
        else $error("timer clock input not forwarded");

    a_capture_pass: assert property ($past(rst_n) |-> muxOut.timerB1Capture == $past(pinsIn.portD[2:1]))
        else $error("capture inputs not forwarded");

    a_serial2_pass: assert property ($past(rst_n) |->
        muxOut.serial2Rx == $past(pinsIn.portD[3]) && muxOut.serial2Cts == $past(pinsIn.portD[4]))
        else $error("serial 2 inputs not forwarded");

    a_pd2_push_pull: assert property ($past(rst_n) |->
        muxOut.portDOutEn[2] == $past(st.cfg[pdm_pkg::SLOT_PORTD_DIR][2]))
        else $error("port D pin 2 enable not push-pull");

    a_pf_push_pull: assert property ($past(rst_n) |->
        muxOut.portFOutEn[0] == $past(st.cfg[pdm_pkg::SLOT_PORTF_DIR][0])
        && muxOut.portFOutEn[3] == $past(st.cfg[pdm_pkg::SLOT_PORTF_DIR][3]))
        else $error("port F pin 0 or 3 enable not push-pull");

    a_serial_exclusive: assert property (!(muxOut.serial1En && muxOut.fastSerialEn))
        else $error("both serial channels own port F");

    a_databus_write: assert property ((st.wrPend && st.wrSlot == pdm_pkg::SLOT_PORT1_FN) |->
        ##2 muxOut.dataBusHigh == $past(ahbReq.hwdata[0], 2))
        else $error("data bus high enable does not follow write");

    a_write_only_read: assert property ((addrPhase && !ahbReq.hwrite && reqIdx != `PDM_IDX_STATUS)
        |=> hrdata == 32'h0000_0000)
        else $error("configuration register read back nonzero");

    a_analog_follow: assert property ((st.wrPend && st.wrSlot == pdm_pkg::SLOT_PORTG_FN) |->
        ##2 muxOut.analogGEn == $past(ahbReq.hwdata[7:0], 2))
        else $error("analog enables do not follow write");

    a_port1_dir_follow: assert property ($past(rst_n) |->
        muxOut.portDir[7:0]
        == $past(st.cfg[pdm_pkg::SLOT_PORT1_DIR]))
        else $error("port 1 directions not followed");

    a_port4_dir_follow: assert property ($past(rst_n) |->
        muxOut.portDir[15:8]
        == $past(st.cfg[pdm_pkg::SLOT_PORT4_DIR]))
        else $error("port 4 directions not followed");

    a_port5_dir_follow: assert property ($past(rst_n) |->
        muxOut.portDir[23:16]
        == $past(st.cfg[pdm_pkg::SLOT_PORT5_DIR]))
        else $error("port 5 directions not followed");

    a_port6_dir_follow: assert property ($past(rst_n) |->
        muxOut.portDir[31:24]
        == $past(st.cfg[pdm_pkg::SLOT_PORT6_DIR]))
        else $error("port 6 directions not followed");

    a_portn_dir_follow: assert property ($past(rst_n) |->
        muxOut.portDir[39:32]
        == $past(st.cfg[pdm_pkg::SLOT_PORTN_DIR]))
        else $error("port N directions not followed");

    a_port4_addr_follow: assert property ($past(rst_n) |->
        muxOut.addrBusEn[7:0]
        == $past(st.cfg[pdm_pkg::SLOT_PORT4_FN]))
        else $error("port 4 address enables not followed");

    a_port5_addr_follow: assert property ($past(rst_n) |->
        muxOut.addrBusEn[15:8]
        == $past(st.cfg[pdm_pkg::SLOT_PORT5_FN]))
        else $error("port 5 address enables not followed");

    a_port6_addr_follow: assert property ($past(rst_n) |->
        muxOut.addrBusEn[23:16]
        == $past(st.cfg[pdm_pkg::SLOT_PORT6_FN]))
        else $error("port 6 address enables not followed");

    a_port7_dir_follow: assert property ($past(rst_n) |->
        muxOut.port7Dir
        == $past(st.cfg[pdm_pkg::SLOT_PORT7_DIR]))
        else $error("port 7 directions not followed");

    a_port7_fn_follow: assert property ($past(rst_n) |->
        muxOut.port7Function
        == $past(st.cfg[pdm_pkg::SLOT_PORT7_FN][4:0]))
        else $error("port 7 functions not followed");

    a_chip_select_follow: assert property ($past(rst_n) |->
        muxOut.chipSelectEn
        == $past(st.cfg[pdm_pkg::SLOT_PORT8_FN][2:0]))
        else $error("chip selects not followed");

    a_wait_input_decode: assert property ($past(rst_n) |->
        muxOut.waitInputEn
        == $past(~st.cfg[pdm_pkg::SLOT_PORT8_DIR][`PDM_PIN_WAIT]
                 & st.cfg[pdm_pkg::SLOT_PORT8_FN][`PDM_PIN_WAIT]))
        else $error("wait input decode wrong");

    a_chip_select3_decode: assert property ($past(rst_n) |->
        muxOut.chipSelect3En
        == $past(st.cfg[pdm_pkg::SLOT_PORT8_DIR][`PDM_PIN_WAIT]
                 & st.cfg[pdm_pkg::SLOT_PORT8_FN][`PDM_PIN_WAIT]))
        else $error("chip select 3 decode wrong");

    a_timer_out_follow: assert property ($past(rst_n) |->
        muxOut.timerOutSel
        == $past({st.cfg[pdm_pkg::SLOT_PORT8_FN2][3], st.cfg[pdm_pkg::SLOT_PORT8_FN2][1:0]}))
        else $error("timer output choice not followed");

    a_serial2_clock_pass: assert property ($past(rst_n) |->
        muxOut.serial2Clk
        == $past(pinsIn.portD[4]))
        else $error("serial 2 clock not forwarded");

    a_serial1_select: assert property ($past(rst_n) |->
        muxOut.serial1En
        == $past(~st.cfg[pdm_pkg::SLOT_SERIAL_SEL][`PDM_BIT_SERIAL_SEL]
                 & portFSerial(st.cfg[pdm_pkg::SLOT_PORTF_FN])))
        else $error("serial 1 choice wrong");

    a_fast_select: assert property ($past(rst_n) |->
        muxOut.fastSerialEn
        == $past(st.cfg[pdm_pkg::SLOT_SERIAL_SEL][`PDM_BIT_SERIAL_SEL]
                 & portFSerial(st.cfg[pdm_pkg::SLOT_PORTF_FN])))
        else $error("fast serial choice wrong");

    a_selector_one_bit: assert property (
        st.cfg[pdm_pkg::SLOT_SERIAL_SEL][7:1] == 7'h00)
        else $error("serial selector holds more than one bit");

    a_analog_l_follow: assert property ($past(rst_n) |->
        muxOut.analogLEn
        == $past(st.cfg[pdm_pkg::SLOT_PORTL_FN][3:0]))
        else $error("port L analog enables not followed");

    a_status_pullup_read: assert property (
        (addrPhase && !ahbReq.hwrite && reqIdx == `PDM_IDX_STATUS)
        |=> hrdata[3:0] == $past(muxOut.port7PullUp))
        else $error("status pull-up field wrong");

    c_wait_input: cover property (muxOut.waitInputEn);
    c_serial1_port: cover property (muxOut.serial1En);
    c_chip_select3: cover property (muxOut.chipSelect3En);
    c_fast_serial: cover property (muxOut.fastSerialEn);
    c_pd1_open_drain: cover property (st.cfg[pdm_pkg::SLOT_PORTD_FN2][1] && st.cfg[pdm_pkg::SLOT_PORTD_FN][1]
                                      && st.cfg[pdm_pkg::SLOT_PORTD_DIR][1]);

endmodule : pdm_port_mux

//--- verification/pdm_pin_model.sv
/*
 Far-side pin model: drives the port C and port D pin levels and the port D
 output data that the mux routes and qualifies.
 Assumes the bench hands it a fresh pattern after a rising edge.
*/
`timescale 1ns/1ps

module pdm_pin_model (
    input wire logic sys_clk,
    input wire logic [13:0] pat,
    output pdm_pkg::pdm_pins_t pinsOut = '0
);
    // Pins are registered so they settle one edge after the bench sets them
    always @(posedge sys_clk) begin
        pinsOut <= pat;
    end
endmodule : pdm_pin_model

//--- verification/test_pdm_port_mux.sv
/*
 Self-checking bench of the port mux: AHB-Lite master tasks, expectation
 queue and an output monitor.
 Assumes hreadyout feeds hready and a single word per register.
*/
`timescale 1ns/1ps
`include "pdm_defines.svh"

module test_pdm_port_mux;
    typedef struct {int kind; logic [39:0] exp;} pdm_note_t;
    localparam logic [7:0] CFG [24] = '{8'h06, 8'h07, 8'h12, 8'h13, 8'h16, 8'h17, 8'h1A, 8'h1B, 8'h1E, 8'h1F,
        8'h21, 8'h22, 8'h23, 8'h33, 8'h35, 8'h36, 8'h37, 8'h3D, 8'h3E, 8'h3F, 8'h43, 8'h57, 8'h5E, 8'h5F};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    pdm_pkg::pdm_ahb_req_t ahbReq = '0;
    logic [13:0] pinPat = 14'h0000;
    pdm_pkg::pdm_pins_t pinsIn;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pdm_pkg::pdm_mux_t muxOut;
    logic rdPhase = 1'b0;
    logic muxChk = 1'b0;
    pdm_note_t notes [$];
    pdm_note_t nt;
    logic [39:0] seen;
    int error_cnt = 0;
    int n_tests = 0;
    logic [31:0] rnd = 32'h00000057;
    logic [7:0] v;
    logic [7:0] w;

    always #10 sys_clk = ~sys_clk;

    pdm_pin_model pins (.sys_clk(sys_clk), .pat(pinPat), .pinsOut(pinsIn));

    pdm_port_mux DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ahbReq(ahbReq), .hready(hreadyout), .pinsIn(pinsIn),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .muxOut(muxOut));

    function automatic logic [31:0] rand32();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : rand32

    task automatic check(input string nm, input logic [39:0] s, input logic [39:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, s);
        end
    endtask : check

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Bounded wait for the slave's ready; a hang ends the run
    task automatic wait_ready();
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask : wait_ready

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        ahbReq.hsel <= 1'b1;
        ahbReq.haddr <= {22'h000000, idx, 2'b00};
        ahbReq.htrans <= 2'b10;
        ahbReq.hwrite <= wr;
        ahbReq.hsize <= 3'b010;
        wait_ready();
        ahbReq.hsel <= 1'b0;
        ahbReq.htrans <= 2'b00;
        ahbReq.hwdata <= d;
        rdPhase <= ~wr;
        wait_ready();
        rdPhase <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, {24'h000000, d});
    endtask : wr

    task automatic rd_exp(input logic [7:0] idx, input logic [7:0] e);
        notes.push_back('{0, {32'h00000000, e}});
        xfer(1'b0, idx, 32'h00000000);
    endtask : rd_exp

    // One idle edge lets a register write reach muxOut first
    task automatic mux_exp(input int k, input logic [39:0] e);
        @(posedge sys_clk);
        notes.push_back('{k, e});
        muxChk <= 1'b1;
        @(posedge sys_clk);
        muxChk <= 1'b0;
    endtask : mux_exp

    always @(posedge sys_clk) begin
        if (rdPhase || muxChk) begin
            if (notes.size() == 0) begin
                error_cnt++;
            end else begin
                nt = notes.pop_front();
                case (nt.kind)
                    0: seen = {8'h00, hrdata};
                    1: seen = 40'(muxOut.dataBusHigh);
                    2: seen = 40'(muxOut.port7PullUp);
                    3: seen = 40'(muxOut.chipSelectEn);
                    4: seen = 40'(muxOut.addrBusEn);
                    7: seen = 40'(muxOut.timerOutSel);
                    8: seen = 40'(muxOut.port7Function);
                    9: seen = muxOut.portDir;
                    5: seen = 40'({muxOut.chipSelect3En, muxOut.waitInputEn});
                    6: seen = 40'({muxOut.serial2Cts, muxOut.serial2Clk, muxOut.serial2Rx, muxOut.timerB1Capture,
                        muxOut.timerA0Clock});
                    10: seen = 40'(muxOut.portDOutEn);
                    11: seen = 40'(muxOut.portFOutEn);
                    12: seen = 40'({muxOut.fastSerialEn, muxOut.serial1En});
                    14: seen = 40'(muxOut.analogGEn);
                    15: seen = 40'(muxOut.analogLEn);
                    16: seen = 40'(muxOut.portDir[15:8]);
                    default: seen = 40'(muxOut.port7Dir);
                endcase
                check($sformatf("output %0d", nt.kind), seen, nt.exp);
                if (nt.kind == 0) begin
                    check("hresp", 40'(hresp), 40'h0000000000);
                end
            end
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Status mirrors the outputs, which show the reset decode one edge after release
        @(posedge sys_clk);
        rd_exp(`PDM_IDX_STATUS, 8'h0F);
        mux_exp(14, 40'hFF);
        mux_exp(15, 40'h0F);
        for (int i = 0; i < 24; i++) begin
            rd_exp(CFG[i], 8'h00);
        end
        rd_exp(8'h01, 8'h00);
        wr(`PDM_IDX_PORT1_FN, 8'h01);
        mux_exp(1, 40'h1);
        rd_exp(`PDM_IDX_STATUS, 8'h4F);
        rd_exp(`PDM_IDX_PORT1_FN, 8'h00);
        wr(`PDM_IDX_PORT1_FN, 8'h00);
        mux_exp(1, 40'h0);
        for (int i = 0; i < 4; i++) begin
            v = 8'(rand32());
            w = 8'(rand32());
            wr(`PDM_IDX_PORT7_DIR, w);
            wr(`PDM_IDX_PORT7_DATA, v); // Whole-register writes only
            mux_exp(2, 40'(~w[3:0] & v[3:0]));
            mux_exp(17, 40'(w));
        end
        wr(`PDM_IDX_PORT7_DIR, 8'hC0); // Slow oscillator set-up
        wr(`PDM_IDX_PORT7_DATA, 8'h40);
        mux_exp(2, 40'h0);
        for (int i = 0; i < 4; i++) begin
            v = 8'(rand32());
            w = 8'(rand32());
            v[3] = i[1];
            w[3] = i[0];
            wr(`PDM_IDX_PORT8_FN, v); // Function before direction
            wr(`PDM_IDX_PORT8_DIR, w);
            mux_exp(3, 40'(v[2:0]));
            mux_exp(5, 40'({v[3] & w[3], v[3] & ~w[3]}));
        end
        // Open-drain code on every bit shows which pins can float
        wr(`PDM_IDX_PORTD_FN2, 8'hFF);
        wr(`PDM_IDX_PORTD_FN, 8'hFF);
        wr(`PDM_IDX_PORTD_DIR, 8'h1F);
        for (int i = 0; i < 8; i++) begin
            wr(`PDM_IDX_PORTC_FN, 8'(rand32()));
            pinPat <= 14'(rand32());
            @(posedge sys_clk);
            mux_exp(6, 40'({pinPat[9], pinPat[9], pinPat[8], pinPat[7:6], pinPat[10]}));
            mux_exp(10, 40'({3'b111, ~pinPat[1], 1'b1}));
        end
        w = 8'(rand32());
        wr(`PDM_IDX_PORTF_DIR, w);
        mux_exp(11, 40'(w[5:0]));
        for (int i = 0; i < 4; i++) begin
            v = 8'(rand32());
            if (i[0]) begin
                v[5:3] = 3'b000;
            end
            wr(`PDM_IDX_SERIAL_SEL, 8'(i[1]));
            wr(`PDM_IDX_PORTF_FN, v);
            mux_exp(12, 40'({i[1] & |v[5:3], ~i[1] & |v[5:3]}));
        end
        v = 8'(rand32());
        wr(`PDM_IDX_PORTG_FN, v);
        wr(`PDM_IDX_PORTL_FN, v);
        mux_exp(14, 40'(v));
        mux_exp(15, 40'(v[3:0]));
        wr(`PDM_IDX_PORT4_DIR, w);
        mux_exp(16, 40'(w));
        v = 8'(rand32());
        wr(`PDM_IDX_PORT5_FN, v);
        wr(`PDM_IDX_PORT7_FN, v);
        wr(`PDM_IDX_PORT8_FN2, v);
        wr(`PDM_IDX_PORTN_DIR, v);
        mux_exp(4, 40'({8'h00, v, 8'h00}));
        mux_exp(7, 40'({v[3], v[1:0]}));
        mux_exp(8, 40'(v[4:0]));
        mux_exp(9, {v, 16'h0000, w, 8'h00});
        complete_run();
    end
endmodule : test_pdm_port_mux
